// ---- smm_ee_model.sv ----
// Behavioural model of the bus engine and configuration EEPROM on the far side.
// Assumes the start pulse from the block; answers dly+1 cycles after the start, pass or fail.
`timescale 1ns/1ps

// =====================================================
// EEPROM load engine model
module smm_ee_model (
  input wire clk,
  input wire start,
  input wire bad,
  input wire [7:0] dly,
  output reg ok,
  output reg fail,
  output reg scl_low
);
  reg [7:0] cnt = 8'h00;
  reg busy = 1'b0;
  initial begin
    ok = 1'b0;
    fail = 1'b0;
    scl_low = 1'b0;
  end
  always @(posedge clk) begin
    ok <= 1'b0;
    fail <= 1'b0;
    if (start) begin
      busy <= 1'b1;
      cnt <= dly;
    end else if (busy) begin
      // Toggle the clock request so the block must follow it, not a constant
      scl_low <= ~scl_low;
      cnt <= cnt - 8'h01;
      if (cnt == 8'h00) begin
        busy <= 1'b0;
        scl_low <= 1'b0;
        ok <= ~bad;
        fail <= bad;
      end
    end
  end
endmodule // smm_ee_model

// ---- smm_pin_mux.v ----
// Mode-dependent pin function logic of an eight-lane redriver.
// Assumes decoded strap level codes and an external bus engine that
// performs register writes and reports EEPROM load pass or fail.
`timescale 1ns/1ps
`include "smm_regs.vh"

module smm_pin_mux (
  input wire MCLK,
  input wire RESETN,
  input wire [1:0] MANAGEMENT_MODE_SELECT,
  input wire [1:0] GROUP_A_EQUALIZATION_LEVEL,
  input wire [1:0] GROUP_B_EQUALIZATION_LEVEL,
  input wire [1:0] LOAD_REQ_THRESHOLD_PIN,
  input wire GROUP_A_SWING0_SDA_I,
  input wire GROUP_A_SWING1_SCL_I,
  input wire GROUP_B_SWING0_AD1,
  input wire GROUP_B_SWING1_AD0,
  input wire SLAVE_ADDRESS_STRAP2,
  input wire [1:0] SPARE_STRAP_TWO,
  input wire [1:0] SPARE_STRAP_THREE,
  input wire BUS_SCL_DRIVE_LOW,
  input wire BUS_SDA_DRIVE_LOW,
  input wire EE_LOAD_OK,
  input wire EE_LOAD_FAIL,
  input wire REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  output reg [1:0] MODE,
  output reg STRAPS_VALID,
  output reg [3:0] SLAVE_ADDRESS,
  output reg [15:0] LANE_EQ,
  output reg [15:0] LANE_SWING,
  output reg [1:0] SIGNAL_DETECT_THRESHOLD,
  output reg SD_READBACK_EN,
  output reg EE_LOAD_START,
  output reg ALL_DONE,
  output reg SCL_O,
  output reg SCL_OE_N,
  output reg SDA_O,
  output reg SDA_OE_N
);

  localparam [31:0] SETTLE_FULL = `SMM_STRAP_SETTLE_CYC;
  localparam [7:0] SETTLE_CYC = SETTLE_FULL[7:0];
  localparam [2:0] ST_SETTLE = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_LOAD = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;
  localparam [2:0] ST_STALL = 3'h4;

  reg [2:0] state;
  reg [7:0] settle_cnt;
  reg capture;
  reg [7:0] sd_cfg;
  reg [1:0] lane_eq_reg [0:7];
  reg [1:0] lane_sw_reg [0:7];
  reg [1:0] next_mode;
  wire [1:0] mode_raw, eqa_s, eqb_s, sdth_s;
  wire [1:0] swa_s, swb_s;
  wire ad2_s;
  wire bus_mode;
  wire loading;
  integer i;
  integer j;

  // =====================================================================
  // Strap capture, once per reset
  smm_strap_latch #(.W(2)) u_mode (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin(MANAGEMENT_MODE_SELECT), .value(mode_raw));
  smm_strap_latch #(.W(2)) u_eqa (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin(GROUP_A_EQUALIZATION_LEVEL), .value(eqa_s));
  smm_strap_latch #(.W(2)) u_eqb (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin(GROUP_B_EQUALIZATION_LEVEL), .value(eqb_s));
  smm_strap_latch #(.W(2)) u_swa (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin({GROUP_A_SWING1_SCL_I, GROUP_A_SWING0_SDA_I}), .value(swa_s));
  smm_strap_latch #(.W(2)) u_swb (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin({GROUP_B_SWING1_AD0, GROUP_B_SWING0_AD1}), .value(swb_s));
  smm_strap_latch #(.W(2)) u_sdth (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin(LOAD_REQ_THRESHOLD_PIN), .value(sdth_s));
  smm_strap_latch #(.W(1)) u_ad2 (.clk(MCLK), .resetn(RESETN), .capture(capture),
    .pin(SLAVE_ADDRESS_STRAP2), .value(ad2_s));

  // Fourth level code counts as high: only low and float are distinct
  always @* begin
    if (mode_raw == `SMM_LVL_LOW) begin
      next_mode = `SMM_MODE_PIN;
    end else if (mode_raw == `SMM_LVL_FLOAT) begin
      next_mode = `SMM_MODE_MASTER;
    end else begin
      next_mode = `SMM_MODE_SLAVE;
    end
  end

  assign bus_mode = (MODE != `SMM_MODE_PIN);
  assign loading = (state == ST_LOAD);

  // =====================================================================
  // Settle timer and load sequence
  always @(posedge MCLK) begin
    if (!RESETN) begin
      state <= ST_SETTLE;
      settle_cnt <= 8'h00;
      capture <= 1'b0;
      STRAPS_VALID <= 1'b0;
      MODE <= `SMM_MODE_PIN;
      EE_LOAD_START <= 1'b0;
      ALL_DONE <= 1'b1;
    end else begin
      EE_LOAD_START <= 1'b0;
      capture <= 1'b0;
      case (state)
        ST_SETTLE: begin
          settle_cnt <= settle_cnt + 8'h01;
          if (settle_cnt == SETTLE_CYC - 8'h01) begin
            capture <= 1'b1;
          end
          if (capture) begin
            STRAPS_VALID <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          MODE <= next_mode;
          // Pin is a load request in master mode only while idle; after the load it is ignored
          if (next_mode == `SMM_MODE_MASTER && LOAD_REQ_THRESHOLD_PIN == `SMM_LVL_LOW) begin
            EE_LOAD_START <= 1'b1;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (EE_LOAD_FAIL) begin
            state <= ST_STALL;
          end else if (EE_LOAD_OK) begin
            ALL_DONE <= 1'b0;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          ALL_DONE <= 1'b0;
        end
        ST_STALL: begin
          ALL_DONE <= 1'b1; // No way out but reset
        end
        default: begin
          state <= ST_SETTLE;
        end
      endcase
    end
  end

  // =====================================================================
  // Registers; only meaningful once a bus mode is active
  always @(posedge MCLK) begin
    if (!RESETN) begin
      sd_cfg <= `SMM_SD_CFG_RESET;
      for (i = 0; i < 8; i = i + 1) begin
        lane_eq_reg[i] <= `SMM_LANE_EQ_RESET;
        lane_sw_reg[i] <= `SMM_LANE_SW_RESET;
      end
    end else if (REG_WR && bus_mode && state != ST_STALL) begin
      if (REG_ADDR == `SMM_REG_SD_CFG) begin
        sd_cfg <= REG_WDATA;
      end else if ((REG_ADDR & `SMM_LANE_MASK) == `SMM_REG_LANE_EQ) begin
        lane_eq_reg[REG_ADDR[2:0]] <= REG_WDATA[1:0];
      end else if ((REG_ADDR & `SMM_LANE_MASK) == `SMM_REG_LANE_SW) begin
        lane_sw_reg[REG_ADDR[2:0]] <= REG_WDATA[1:0];
      end
    end
  end

  always @(posedge MCLK) begin
    if (!RESETN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_ADDR == `SMM_REG_SD_CFG) begin
      REG_RDATA <= sd_cfg;
    end else if (REG_ADDR == `SMM_REG_STATUS) begin
      REG_RDATA <= {2'h0, MODE, ALL_DONE, state};
    end else if ((REG_ADDR & `SMM_LANE_MASK) == `SMM_REG_LANE_EQ) begin
      REG_RDATA <= {6'h00, lane_eq_reg[REG_ADDR[2:0]]};
    end else if ((REG_ADDR & `SMM_LANE_MASK) == `SMM_REG_LANE_SW) begin
      REG_RDATA <= {6'h00, lane_sw_reg[REG_ADDR[2:0]]};
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  // =====================================================================
  // Lane settings and pin functions
  always @(posedge MCLK) begin
    if (!RESETN) begin
      LANE_EQ <= 16'h0000;
      LANE_SWING <= 16'h0000;
      SLAVE_ADDRESS <= 4'h0;
      SIGNAL_DETECT_THRESHOLD <= `SMM_SIGNAL_DETECT_THRESHOLD_DEFAULT;
      SD_READBACK_EN <= 1'b0;
      SCL_O <= 1'b0;
      SCL_OE_N <= 1'b1;
      SDA_O <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      SD_READBACK_EN <= sd_cfg[`SMM_SD_READBACK_BIT];
      for (j = 0; j < 4; j = j + 1) begin
        if (bus_mode) begin
          LANE_EQ[2*j +: 2] <= lane_eq_reg[j];
          LANE_EQ[2*j+8 +: 2] <= lane_eq_reg[j+4];
          LANE_SWING[2*j +: 2] <= lane_sw_reg[j];
          LANE_SWING[2*j+8 +: 2] <= lane_sw_reg[j+4];
        end else begin
          LANE_EQ[2*j +: 2] <= eqa_s;
          LANE_EQ[2*j+8 +: 2] <= eqb_s;
          LANE_SWING[2*j +: 2] <= swa_s;
          LANE_SWING[2*j+8 +: 2] <= swb_s;
        end
      end
      if (bus_mode) begin
        // Group B equalization pin reads as a logic level here
        SLAVE_ADDRESS <= {eqb_s != `SMM_LVL_LOW, ad2_s, swb_s[0], swb_s[1]};
      end else begin
        SLAVE_ADDRESS <= 4'h0;
      end
      // Decoded mode, so the strap never shows for a cycle as master mode starts
      if (next_mode != `SMM_MODE_MASTER) begin
        SIGNAL_DETECT_THRESHOLD <= sdth_s;
      end else begin
        SIGNAL_DETECT_THRESHOLD <= `SMM_SIGNAL_DETECT_THRESHOLD_DEFAULT;
      end
      // Open drain: output is always low, enable gates it
      SCL_O <= 1'b0;
      SDA_O <= 1'b0;
      SCL_OE_N <= ~(bus_mode && STRAPS_VALID && (loading || MODE == `SMM_MODE_SLAVE)
        && BUS_SCL_DRIVE_LOW);
      SDA_OE_N <= ~(bus_mode && STRAPS_VALID && BUS_SDA_DRIVE_LOW);
    end
  end

endmodule // smm_pin_mux

// ---- smm_pin_mux_monitor.sv ----
// Concurrent checks on the ports of the pin function block.
// Assumes binding to every instance of the block; one clock domain.
`timescale 1ns/1ps

// =====================================================
// Checker
module smm_pin_mux_monitor (
  input wire MCLK,
  input wire RESETN,
  input wire [1:0] LOAD_REQ_THRESHOLD_PIN,
  input wire BUS_SCL_DRIVE_LOW,
  input wire BUS_SDA_DRIVE_LOW,
  input wire EE_LOAD_OK,
  input wire EE_LOAD_FAIL,
  input wire [1:0] MODE,
  input wire STRAPS_VALID,
  input wire [3:0] SLAVE_ADDRESS,
  input wire [1:0] SIGNAL_DETECT_THRESHOLD,
  input wire EE_LOAD_START,
  input wire ALL_DONE,
  input wire SCL_OE_N,
  input wire SDA_OE_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  a_start_needs_req: assert property (EE_LOAD_START |->
    MODE == 2'h1 && $past(LOAD_REQ_THRESHOLD_PIN) == 2'h0) else $error("bad load start");
  a_thr_kept_load: assert property (MODE == 2'h1 |->
    SIGNAL_DETECT_THRESHOLD == 2'h1) else $error("threshold used in master");
  a_fail_stalls: assert property (EE_LOAD_FAIL |=> ALL_DONE [*8])
    else $error("done fell after fail");
  a_done_on_pass: assert property ($fell(ALL_DONE) |->
    $past(EE_LOAD_OK) && !$past(EE_LOAD_FAIL)) else $error("done fell without pass");
  a_done_stays_low: assert property (!ALL_DONE |=> !ALL_DONE)
    else $error("done rose after pass");
  a_scl_released: assert property (MODE == 2'h1 && !ALL_DONE |=> SCL_OE_N)
    else $error("clock driven after load");
  a_pin_no_bus: assert property (MODE == 2'h0 |-> SCL_OE_N && SDA_OE_N)
    else $error("bus wire driven in pin mode");
  a_sda_follows: assert property (MODE == 2'h2 && $past(MODE) == 2'h2 |->
    SDA_OE_N == !$past(BUS_SDA_DRIVE_LOW)) else $error("data wire wrong");
  a_scl_slave: assert property (MODE == 2'h2 && $past(MODE) == 2'h2 |->
    SCL_OE_N == !$past(BUS_SCL_DRIVE_LOW)) else $error("clock wire wrong");
  a_straps_fixed: assert property ($past(STRAPS_VALID, 3) && STRAPS_VALID |->
    $stable(MODE) && $stable(SLAVE_ADDRESS)) else $error("strap result changed");
endmodule // smm_pin_mux_monitor

bind smm_pin_mux smm_pin_mux_monitor mon_u (.*);

// ---- smm_regs.vh ----
// Constants for the strap and mode pin function block.
// Assumes one 125 MHz clock and straps that are settled by power-up.
// Operation
// - Mode strap high/float/low picks slave/master/pin
// - Low load request starts EEPROM configuration load
// - Load request pin never reverts to threshold input
// - Failed EEPROM load stalls device forever
// - Load-done output stays high after failed load
// - Load-done high until load passes, then low
// - Master drives bus clock while loading only
// - Group equalization straps set group lane equalization
// - Equalization straps set lane equalization only in pin mode
// - Bus modes: per-lane equalization, group B eq is address three
// - Pin mode: group B swing strap sets amplitude
// - Bus modes: group B swing pins become address
// - Pin mode: group A swing strap sets amplitude
// - Bus modes: group A swing pins carry bus wires
// - Threshold strap used in pin and slave modes
// - Bus modes: address straps give slave address
`ifndef SMM_REGS_VH
`define SMM_REGS_VH

// =====================================================================
// Strap level codes
`define SMM_LVL_LOW 2'h0
`define SMM_LVL_FLOAT 2'h1
`define SMM_LVL_HIGH 2'h2

// =====================================================================
// Modes
`define SMM_MODE_PIN 2'h0
`define SMM_MODE_MASTER 2'h1
`define SMM_MODE_SLAVE 2'h2

// =====================================================================
// Register offsets and fields
`define SMM_REG_STATUS 8'h01
`define SMM_REG_SD_CFG 8'h08
`define SMM_REG_LANE_EQ 8'h10
`define SMM_REG_LANE_SW 8'h20
`define SMM_LANE_MASK 8'hF8
`define SMM_SD_CFG_RESET 8'h00
`define SMM_SD_READBACK_BIT 2
`define SMM_LANE_EQ_RESET 2'h0
`define SMM_LANE_SW_RESET 2'h0
`define SMM_SIGNAL_DETECT_THRESHOLD_DEFAULT 2'h1

// =====================================================================
// Timing
`define SMM_CLK_PERIOD_NS 8
`define SMM_STRAP_SETTLE_NS 100
`define SMM_STRAP_SETTLE_CYC ((`SMM_STRAP_SETTLE_NS + `SMM_CLK_PERIOD_NS - 1) / `SMM_CLK_PERIOD_NS)

`endif

// ---- smm_strap_latch.v ----
// One strap capture register, loaded once by a capture strobe.
// Assumes the strap input is steady while the strobe is high.
`timescale 1ns/1ps

module smm_strap_latch #(
  parameter W = 2
) (
  input wire clk,
  input wire resetn,
  input wire capture,
  input wire [W-1:0] pin,
  output reg [W-1:0] value
);

  // =====================================================================
  // Capture after reset release, never from reset itself
  always @(posedge clk) begin
    if (!resetn) begin
      value <= {W{1'b0}};
    end else if (capture) begin
      value <= pin;
    end
  end

endmodule // smm_strap_latch

// ---- tb_strap_mode_pin_mux.sv ----
// Self-checking bench for the pin function block in all three modes.
// Assumes the EEPROM engine model and the bound checker alongside.
`timescale 1ns/1ps
`include "smm_regs.vh"

// =====================================================
// Bench
module tb_strap_mode_pin_mux;
  reg mclk = 1'b0;
  reg resetn = 1'b0;
  reg [1:0] mms = 2'h0, group_a_equalization_level = 2'h2, group_b_equalization_level = 2'h1, ldp = 2'h2;
  reg sda_i = 1'b0, scl_i = 1'b1, swb0 = 1'b1, swb1 = 1'b0, ad2 = 1'b0;
  reg sda_lo = 1'b0, wr = 1'b0, bad = 1'b0, lo;
  reg [7:0] addr = 8'h00, wdata = 8'h00, dly = 8'h04;
  wire [7:0] rdata;
  wire [1:0] mode, thr;
  wire [3:0] saddr;
  wire [15:0] leq, lsw;
  wire valid, sd_en, start, done, scl_oe_n, sda_oe_n, ok, fail, scl_lo, scl_o, sda_o;
  integer n_fail = 0, checks_done = 0, i;
  always #4 mclk = ~mclk;
  smm_ee_model ee_u (.clk(mclk), .start(start), .bad(bad), .dly(dly), .ok(ok), .fail(fail),
    .scl_low(scl_lo));
  smm_pin_mux dut_u (.MCLK(mclk), .RESETN(resetn), .MANAGEMENT_MODE_SELECT(mms),
    .GROUP_A_EQUALIZATION_LEVEL(group_a_equalization_level), .GROUP_B_EQUALIZATION_LEVEL(group_b_equalization_level),
    .LOAD_REQ_THRESHOLD_PIN(ldp), .GROUP_A_SWING0_SDA_I(sda_i), .GROUP_A_SWING1_SCL_I(scl_i),
    .GROUP_B_SWING0_AD1(swb0), .GROUP_B_SWING1_AD0(swb1), .SLAVE_ADDRESS_STRAP2(ad2),
    .SPARE_STRAP_TWO(2'h1), .SPARE_STRAP_THREE(2'h0), .BUS_SCL_DRIVE_LOW(scl_lo),
    .BUS_SDA_DRIVE_LOW(sda_lo), .EE_LOAD_OK(ok), .EE_LOAD_FAIL(fail), .REG_WR(wr),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .MODE(mode), .STRAPS_VALID(valid),
    .SLAVE_ADDRESS(saddr), .LANE_EQ(leq), .LANE_SWING(lsw), .SIGNAL_DETECT_THRESHOLD(thr),
    .SD_READBACK_EN(sd_en), .EE_LOAD_START(start), .ALL_DONE(done), .SCL_O(scl_o),
    .SCL_OE_N(scl_oe_n), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  // Straps are read once, so every mode needs its own reset
  task boot(input [1:0] m);
    begin
      mms = m;
      resetn = 1'b0;
      cyc(5);
      resetn = 1'b1;
      for (i = 0; i < 50 && valid !== 1'b1; i = i + 1) cyc(1);
      if (i >= 50) n_fail = n_fail + 1;
      cyc(2);
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(2);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    #40000;
    n_fail = n_fail + 1;
    test_done;
  end
  initial begin
    boot(`SMM_LVL_LOW);
    chk(mode, `SMM_MODE_PIN);
    chk(leq, {{4{2'h1}}, {4{2'h2}}});
    chk(lsw, {{4{2'h1}}, {4{2'h2}}});
    chk(thr, 2'h2);
    chk(saddr, 4'h0);
    wr_reg(`SMM_REG_SD_CFG, 8'h04);
    chk(sd_en, 1'b0);
    group_a_equalization_level = 2'h0;
    cyc(3);
    chk(leq, {{4{2'h1}}, {4{2'h2}}});
    $display("pin mode test ended");
    group_b_equalization_level = 2'h2; ad2 = 1'b1; swb0 = 1'b0; swb1 = 1'b1; ldp = 2'h0;
    boot(`SMM_LVL_HIGH);
    chk(mode, `SMM_MODE_SLAVE);
    chk(saddr, 4'hD);
    chk(thr, 2'h0);
    chk(start, 1'b0);
    wr_reg(`SMM_REG_SD_CFG, 8'h04);
    chk(sd_en, 1'b1);
    addr = `SMM_REG_SD_CFG;
    cyc(1);
    chk(rdata, 8'h04);
    wr_reg(8'h13, 8'h03);
    chk(leq, 16'h00C0);
    wr_reg(8'h24, 8'h02);
    chk(lsw, 16'h0200);
    addr = 8'h40;
    cyc(1);
    chk(rdata, 8'h00);
    sda_lo = 1'b1;
    cyc(2);
    chk(sda_oe_n, 1'b0);
    chk({scl_o, sda_o}, 2'h0);
    sda_lo = 1'b0;
    $display("slave mode test ended");
    ldp = 2'h2;
    boot(`SMM_LVL_FLOAT);
    chk(mode, `SMM_MODE_MASTER);
    cyc(3);
    chk(done, 1'b1);
    ldp = 2'h0;
    lo = 1'b0;
    for (i = 0; i < 100 && done !== 1'b0; i = i + 1) begin
      cyc(1);
      if (scl_oe_n === 1'b0) lo = 1'b1;
    end
    chk(lo, 1'b1);
    chk(done, 1'b0);
    cyc(2);
    chk(scl_oe_n, 1'b1);
    addr = `SMM_REG_STATUS;
    cyc(1);
    chk(rdata[5:3], {`SMM_MODE_MASTER, 1'b0});
    ldp = 2'h2;
    cyc(3);
    chk(thr, 2'h1);
    $display("master pass test ended");
    bad = 1'b1; dly = 8'h28; ldp = 2'h0;
    boot(`SMM_LVL_FLOAT);
    cyc(150);
    chk(done, 1'b1);
    wr_reg(`SMM_REG_SD_CFG, 8'h04);
    chk(sd_en, 1'b0);
    $display("master fail test ended");
    test_done;
  end
endmodule // tb_strap_mode_pin_mux
